// ==== pkg/enc_defines.svh ====
// Offsets, reset values and timing counts of the encoder parameter bank.
// Guarded against repeated inclusion; definitions only.
`ifndef ENC_DEFINES_SVH
`define ENC_DEFINES_SVH

// ***********************************************************
// Register addresses
// ***********************************************************
`define ENC_A_TIMEOUT     16'h0051
`define ENC_A_POS_HI      16'h005E
`define ENC_A_POS_LO      16'h005F
`define ENC_A_VEL_HI      16'h0060
`define ENC_A_VEL_LO      16'h0061
`define ENC_A_STAT_HI     16'h0062
`define ENC_A_STAT_LO     16'h0063
`define ENC_A_STEPS_HI    16'h0064
`define ENC_A_STEPS_LO    16'h0065
`define ENC_A_RANGE_HI    16'h0066
`define ENC_A_RANGE_LO    16'h0067
`define ENC_A_PRESET_HI   16'h0068
`define ENC_A_PRESET_LO   16'h0069

// ***********************************************************
// Function and exception codes
// ***********************************************************
`define ENC_FC_READ       8'h03
`define ENC_FC_WR_ONE     8'h06
`define ENC_FC_WR_MANY    8'h10
`define ENC_EX_FUNC       8'h01
`define ENC_EX_ADDR       8'h02
`define ENC_EX_VALUE      8'h03

// ***********************************************************
// Reset values and native resolution
// ***********************************************************
`define ENC_TIMEOUT_RST   16'h0000
`define ENC_PRESET_RST    32'h0000_0000
`define ENC_NATIVE_STEPS  32'h0000_2000
`define ENC_NATIVE_TURNS  32'h0000_4000

// ***********************************************************
// Timing
// ***********************************************************
`define ENC_MS_NS         1000000
`define ENC_CLK_NS        10
`define ENC_MS_CYCLES     (`ENC_MS_NS / `ENC_CLK_NS)

`endif

// ==== pkg/enc_pkg.sv ====
// Types shared by the encoder parameter bank and its watchdog.
// Assumes enc_defines.svh is compiled alongside.
package enc_pkg;

   // Watchdog states, Gray coded along off, wait, run, fault.
   typedef enum logic [1:0] {
      WD_OFF   = 2'b00,
      WD_WAIT  = 2'b01,
      WD_RUN   = 2'b11,
      WD_FAULT = 2'b10
   } wd_state_e;

endpackage

// ==== pkg/wd_if.sv ====
// Signals between the register bank and the link watchdog.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface wd_if;
   logic [15:0] timeout_ms;
   logic        cfg_wr;
   logic        msg_seen;
   logic        fault;
   logic        running;

   modport ctl (
      output timeout_ms,
      output cfg_wr,
      output msg_seen,
      input  fault,
      input  running
   );

   modport wd (
      input  timeout_ms,
      input  cfg_wr,
      input  msg_seen,
      output fault,
      output running
   );
endinterface

// ==== verilog/link_watchdog.sv ====
// Millisecond link watchdog of the encoder parameter bank.
// Assumes msg_seen pulses once per received message on clk_sys.
`timescale 1ns/1ps
`include "enc_defines.svh"
module link_watchdog
   import enc_pkg::*;
#(
   parameter int MS_CYCLES = `ENC_MS_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   wd_if.wd          wd
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

   wd_state_e     state_r;
   logic [PW-1:0] pre_r;
   logic [15:0]   ms_left_r;
   logic          tick;

   assign tick       = (pre_r == PRE_LAST);
   assign wd.fault   = (state_r == WD_FAULT);
   assign wd.running = (state_r == WD_RUN);

   // ***********************************************************
   // State and countdown
   // ***********************************************************
   // A new nonzero timeout only takes effect after a later message.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r   <= WD_OFF;
         pre_r     <= '0;
         ms_left_r <= '0;
      end else begin
         unique case (state_r)
            WD_FAULT: begin
               state_r <= WD_FAULT;
            end
            default: begin
               if (wd.cfg_wr) begin
                  state_r <= (wd.timeout_ms == 16'h0000) ?
                             WD_OFF : WD_WAIT;
               end else if (wd.msg_seen &&
                            state_r != WD_OFF) begin
                  state_r   <= WD_RUN;
                  pre_r     <= '0;
                  ms_left_r <= wd.timeout_ms;
               end else if (state_r == WD_RUN) begin
                  pre_r <= tick ? '0 : pre_r + 1'b1;
                  if (tick) begin
                     ms_left_r <= ms_left_r - 16'h0001;
                     if (ms_left_r == 16'h0001) begin
                        state_r <= WD_FAULT;
                     end
                  end
               end
            end
         endcase
      end
   end
endmodule

// ==== verilog/encoder_param_registers.sv ====
// Holding-register parameter bank of a networked absolute encoder.
// Assumes a protocol front end that hands over one register access
// per request cycle, and position logic that supplies the readings.
`timescale 1ns/1ps
`include "enc_defines.svh"

module encoder_param_registers
   import enc_pkg::*;
#(
   parameter logic [31:0] NATIVE_STEPS = `ENC_NATIVE_STEPS,
   parameter logic [31:0] NATIVE_TURNS = `ENC_NATIVE_TURNS,
   parameter int          MS_CYCLES    = `ENC_MS_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        req_valid,
   input  wire logic [7:0]  req_func,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   input  wire logic        req_end,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   output logic             rsp_exc,
   output logic [7:0]       rsp_exc_code,
   input  wire logic        scaled_mode,
   input  wire logic        apply_preset,
   input  wire logic        commit_cmd,
   input  wire logic [31:0] read_pos,
   input  wire logic [31:0] vel_in,
   input  wire logic [31:0] status_in,
   output logic [31:0]      pos_out,
   output logic [31:0]      eff_steps_per_turn,
   output logic [31:0]      eff_full_range,
   output logic [15:0]      link_timeout_ms,
   output logic             nv_save_params,
   output logic             nv_save_timeout,
   output logic             comm_fault_state,
   output logic             net_participate,
   output logic             net_state_indicator
);
   localparam logic [63:0] NATIVE_TOTAL =
      64'(NATIVE_STEPS) * 64'(NATIVE_TURNS);

   // ***********************************************************
   // Storage
   // ***********************************************************
   logic [15:0] timeout_r;
   logic [31:0] steps_r;
   logic [31:0] range_r;
   logic [31:0] preset_r;
   logic [31:0] offset_r;
   logic [31:0] pos_r;
   logic [15:0] pend_hi_r;
   logic [15:0] pend_addr_r;
   logic        pend_ok_r;
   logic        rsp_valid_r;
   logic [15:0] rsp_rdata_r;
   logic        rsp_exc_r;
   logic [7:0]  rsp_code_r;
   logic        nv_par_r;
   logic        nv_to_r;

   wd_if wdb ();

   link_watchdog #(
      .MS_CYCLES (MS_CYCLES)
   ) u_wd (
      .clk_sys (clk_sys),
      .rst     (rst),
      .wd      (wdb.wd)
   );

   // ***********************************************************
   // Request decode
   // ***********************************************************
   logic        take;
   logic        is_rd;
   logic        is_wr;
   logic        hi_half;
   logic [15:0] pair_hi;
   logic [31:0] wval;
   logic [15:0] rd_val;
   logic        known;
   logic        writable;
   logic        val_ok;
   logic [63:0] turns_need;
   logic [63:0] preset_lim;
   logic [7:0]  code;

   assign take  = req_valid && !wdb.fault;
   assign is_rd = (req_func == `ENC_FC_READ);
   assign is_wr = (req_func == `ENC_FC_WR_ONE) ||
                  (req_func == `ENC_FC_WR_MANY);
   // High halves sit at even addresses of the pairs.
   assign hi_half = (req_addr != `ENC_A_TIMEOUT) &&
                    !req_addr[0];

   // A low-half write pairs with a staged high half of the same
   // pair, else with the stored high half, so a lone 06 on the low
   // register leaves the high half as it was.
   always_comb begin
      pair_hi = 16'h0000;
      if (pend_ok_r && pend_addr_r == {req_addr[15:1], 1'b0}) begin
         pair_hi = pend_hi_r;
      end else begin
         unique case (req_addr)
            `ENC_A_STEPS_LO:  pair_hi = steps_r[31:16];
            `ENC_A_RANGE_LO:  pair_hi = range_r[31:16];
            `ENC_A_PRESET_LO: pair_hi = preset_r[31:16];
            default:          pair_hi = 16'h0000;
         endcase
      end
   end

   assign wval = {pair_hi, req_wdata};

   // ***********************************************************
   // Read multiplexer
   // ***********************************************************
   always_comb begin
      rd_val   = 16'h0000;
      known    = 1'b1;
      writable = 1'b0;
      unique case (req_addr)
         `ENC_A_TIMEOUT: begin
            rd_val   = timeout_r;
            writable = 1'b1;
         end
         `ENC_A_POS_HI:    rd_val = pos_r[31:16];
         `ENC_A_POS_LO:    rd_val = pos_r[15:0];
         `ENC_A_VEL_HI:    rd_val = vel_in[31:16];
         `ENC_A_VEL_LO:    rd_val = vel_in[15:0];
         `ENC_A_STAT_HI:   rd_val = status_in[31:16];
         `ENC_A_STAT_LO:   rd_val = status_in[15:0];
         `ENC_A_STEPS_HI,
         `ENC_A_RANGE_HI,
         `ENC_A_PRESET_HI: begin
            rd_val   = (req_addr == `ENC_A_STEPS_HI) ?
                       steps_r[31:16] :
                       (req_addr == `ENC_A_RANGE_HI) ?
                       range_r[31:16] : preset_r[31:16];
            writable = 1'b1;
         end
         `ENC_A_STEPS_LO: begin
            rd_val   = steps_r[15:0];
            writable = 1'b1;
         end
         `ENC_A_RANGE_LO: begin
            rd_val   = range_r[15:0];
            writable = 1'b1;
         end
         `ENC_A_PRESET_LO: begin
            rd_val   = preset_r[15:0];
            writable = 1'b1;
         end
         default: begin
            known = 1'b0;
         end
      endcase
   end

   // ***********************************************************
   // Acceptance checks
   // ***********************************************************
   // The product is formed in 64 bits so that a huge full range
   // with tiny steps cannot wrap and slip past the turn check.
   assign turns_need = 64'(wval) * 64'(NATIVE_TURNS);
   assign preset_lim = scaled_mode ? 64'(range_r) : NATIVE_TOTAL;

   always_comb begin
      val_ok = 1'b1;
      unique case (req_addr)
         `ENC_A_STEPS_LO: begin
            val_ok = (wval != 32'h0000_0000) &&
                     (wval <= NATIVE_STEPS) &&
                     (64'(range_r) <= turns_need);
         end
         `ENC_A_RANGE_LO: begin
            val_ok = (wval != 32'h0000_0000) &&
                     (64'(wval) <= NATIVE_TOTAL) &&
                     (wval >= steps_r);
         end
         `ENC_A_PRESET_LO: begin
            val_ok = (64'(wval) < preset_lim);
         end
         default: begin
            val_ok = 1'b1;
         end
      endcase
   end

   always_comb begin
      code = 8'h00;
      if (!is_rd && !is_wr) begin
         code = `ENC_EX_FUNC;
      end else if (!known || (is_wr && !writable)) begin
         code = `ENC_EX_ADDR;
      end else if (is_wr && !hi_half && !val_ok) begin
         code = `ENC_EX_VALUE;
      end
   end

   // ***********************************************************
   // Parameter storage
   // ***********************************************************
   // Values live in flip-flops only; the parameters survive power loss only
   // once the commit command has copied them out, the timeout once its write has requested a save.
   logic do_wr;
   assign do_wr = take && is_wr && (code == 8'h00);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timeout_r <= `ENC_TIMEOUT_RST;
      end else if (do_wr && req_addr == `ENC_A_TIMEOUT) begin
         timeout_r <= req_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_ok_r   <= 1'b0;
         pend_hi_r   <= 16'h0000;
         pend_addr_r <= 16'h0000;
      end else if (do_wr && hi_half) begin
         pend_ok_r   <= 1'b1;
         pend_hi_r   <= req_wdata;
         pend_addr_r <= req_addr;
      end else if (take && is_wr) begin
         pend_ok_r   <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         steps_r <= NATIVE_STEPS;
      end else if (do_wr && req_addr == `ENC_A_STEPS_LO) begin
         steps_r <= wval;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         range_r <= NATIVE_TOTAL[31:0];
      end else if (do_wr && req_addr == `ENC_A_RANGE_LO) begin
         range_r <= wval;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         preset_r <= `ENC_PRESET_RST;
      end else if (do_wr && req_addr == `ENC_A_PRESET_LO) begin
         preset_r <= wval;
      end
   end

   // ***********************************************************
   // Preset and position
   // ***********************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         offset_r <= 32'h0000_0000;
      end else if (apply_preset) begin
         offset_r <= read_pos;
      end
   end

   // The position register loads the preset directly in the preset cycle, so the
   // first output after a preset already equals the target.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pos_r <= 32'h0000_0000;
      end else if (apply_preset) begin
         pos_r <= preset_r;
      end else begin
         pos_r <= read_pos + preset_r - offset_r;
      end
   end

   assign pos_out = pos_r;
   assign eff_steps_per_turn = scaled_mode ? steps_r
                                           : NATIVE_STEPS;
   assign eff_full_range = scaled_mode ? range_r
                                       : NATIVE_TOTAL[31:0];

   // ***********************************************************
   // Non-volatile save requests
   // ***********************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nv_par_r <= 1'b0;
         nv_to_r  <= 1'b0;
      end else begin
         nv_par_r <= commit_cmd;
         nv_to_r  <= do_wr && (req_addr == `ENC_A_TIMEOUT);
      end
   end

   assign nv_save_params  = nv_par_r;
   assign nv_save_timeout = nv_to_r;

   // ***********************************************************
   // Response
   // ***********************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
         rsp_exc_r   <= 1'b0;
         rsp_code_r  <= 8'h00;
      end else begin
         rsp_valid_r <= take;
         rsp_rdata_r <= (take && is_rd && code == 8'h00) ?
                        rd_val : 16'h0000;
         rsp_exc_r   <= take && (code != 8'h00);
         rsp_code_r  <= take ? code : 8'h00;
      end
   end

   assign rsp_valid    = rsp_valid_r;
   assign rsp_rdata    = rsp_rdata_r;
   assign rsp_exc      = rsp_exc_r;
   assign rsp_exc_code = rsp_code_r;

   // ***********************************************************
   // Watchdog hookup
   // ***********************************************************
   assign wdb.timeout_ms = (do_wr && req_addr == `ENC_A_TIMEOUT) ?
                           req_wdata : timeout_r;
   assign wdb.cfg_wr   = do_wr && (req_addr == `ENC_A_TIMEOUT);
   assign wdb.msg_seen = take && req_end;

   assign link_timeout_ms     = timeout_r;
   assign comm_fault_state    = wdb.fault;
   assign net_participate     = !wdb.fault;
   assign net_state_indicator = wdb.fault;
endmodule

// ==== tb/encoder_param_registers_checker.sv ====
// Concurrent checks on the ports of the encoder parameter bank.
// Assumes it is bound to encoder_param_registers in the bench top file.
`timescale 1ns/1ps
`include "enc_defines.svh"
module encoder_param_registers_checker
#(
   parameter logic [31:0] NATIVE_STEPS = `ENC_NATIVE_STEPS,
   parameter logic [31:0] NATIVE_TURNS = `ENC_NATIVE_TURNS,
   parameter int          MS_CYCLES    = `ENC_MS_CYCLES
) (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        req_valid,
   input wire logic [7:0]  req_func,
   input wire logic [15:0] req_addr,
   input wire logic        rsp_valid,
   input wire logic        rsp_exc,
   input wire logic [7:0]  rsp_exc_code,
   input wire logic        scaled_mode,
   input wire logic        apply_preset,
   input wire logic        commit_cmd,
   input wire logic [31:0] read_pos,
   input wire logic [31:0] pos_out,
   input wire logic [31:0] eff_steps_per_turn,
   input wire logic [31:0] eff_full_range,
   input wire logic [15:0] link_timeout_ms,
   input wire logic        nv_save_params,
   input wire logic        nv_save_timeout,
   input wire logic        comm_fault_state,
   input wire logic        net_participate,
   input wire logic        net_state_indicator
);
   // ***********************************************************
   // Properties
   // ***********************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic take;
   logic wr_func;
   assign take = req_valid && !comm_fault_state;
   assign wr_func = req_func == `ENC_FC_WR_ONE || req_func == `ENC_FC_WR_MANY;

   property p_answer;
      take |=> rsp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_bad_func;
      take && !wr_func && req_func != `ENC_FC_READ
         |=> rsp_exc && rsp_exc_code == `ENC_EX_FUNC;
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("bad func");
   property p_ro_write;
      take && wr_func && req_addr inside {[16'h005E:16'h0063]}
         |=> rsp_exc && rsp_exc_code == `ENC_EX_ADDR;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("ro write");
   property p_fault_silent;
      comm_fault_state && req_valid |=> !rsp_valid;
   endproperty
   a_fault_silent: assert property (p_fault_silent) else $error("fault");
   property p_fault_out;
      comm_fault_state |-> !net_participate && net_state_indicator;
   endproperty
   a_fault_out: assert property (p_fault_out) else $error("net state");
   property p_fault_sticky;
      comm_fault_state |=> comm_fault_state [*3];
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("sticky");
   property p_off_quiet;
      link_timeout_ms == 16'h0000 && !comm_fault_state |=> !comm_fault_state;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("off fault");
   property p_nv_timeout;
      take && req_func == `ENC_FC_WR_ONE && req_addr == `ENC_A_TIMEOUT
         |=> nv_save_timeout;
   endproperty
   a_nv_timeout: assert property (p_nv_timeout) else $error("nv tmo");
   property p_commit;
      commit_cmd |=> nv_save_params ##1 !nv_save_params;
   endproperty
   a_commit: assert property (p_commit) else $error("commit");
   property p_native;
      !scaled_mode |-> eff_steps_per_turn == NATIVE_STEPS
         && eff_full_range == NATIVE_STEPS * NATIVE_TURNS;
   endproperty
   a_native: assert property (p_native) else $error("native res");
   // Output must follow the shaft step for step while nothing reloads it.
   property p_track;
      !apply_preset && !req_valid ##1 !apply_preset && !req_valid
         |=> pos_out - $past(pos_out) == $past(read_pos) - $past(read_pos, 2);
   endproperty
   a_track: assert property (p_track) else $error("pos track");
   property p_preset_hold;
      apply_preset && !req_valid ##1
         ($stable(read_pos) && !apply_preset && !req_valid)
         |=> $stable(pos_out);
   endproperty
   a_preset_hold: assert property (p_preset_hold) else $error("preset");

   c_fault: cover property (comm_fault_state);
   c_preset: cover property (apply_preset);
   c_reject: cover property (rsp_exc && rsp_exc_code == `ENC_EX_VALUE);
endmodule

// ==== tb/remote_master.sv ====
// Behavioural remote protocol master driving one access per cycle.
// Assumes the bench calls its tasks from a falling clock edge.
`timescale 1ns/1ps
module remote_master (
   input  wire logic        clk_sys,
   output logic             req_valid,
   output logic [7:0]       req_func,
   output logic [15:0]      req_addr,
   output logic [15:0]      req_wdata,
   output logic             req_end,
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_rdata,
   input  wire logic        rsp_exc,
   input  wire logic [7:0]  rsp_exc_code
);
   logic        got_valid;
   logic [15:0] got_rdata;
   logic        got_exc;
   logic [7:0]  got_code;

   initial {req_valid, req_func, req_addr, req_wdata, req_end} = '0;

   // Leaves the request up; the caller chains accesses or calls idle.
   task automatic acc(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d, input logic e);
      req_valid = 1'b1;
      req_func  = f;
      req_addr  = a;
      req_wdata = d;
      req_end   = e;
      @(negedge clk_sys);
      got_valid = rsp_valid;
      got_rdata = rsp_rdata;
      got_exc   = rsp_exc;
      got_code  = rsp_exc_code;
   endtask

   // Released address and data lines show inverted values, never the last one; req_func keeps its value.
   task automatic idle();
      req_valid = 1'b0;
      req_end   = 1'b0;
      req_addr  = ~req_addr;
      req_wdata = ~req_wdata;
      @(negedge clk_sys);
   endtask
endmodule

// ==== tb/encoder_param_registers_tb_top.sv ====
// Self-checking bench of the encoder parameter bank.
// Assumes the design package, header and remote_master are compiled first.
`timescale 1ns/1ps
`include "enc_defines.svh"
module encoder_param_registers_tb_top;
   import enc_pkg::*;
   localparam int MS_CYCLES = 10;
   logic clk_sys, rst, scaled_mode, apply_preset, commit_cmd;
   logic req_valid, req_end, rsp_valid, rsp_exc;
   logic [7:0] req_func, rsp_exc_code;
   logic [15:0] req_addr, req_wdata, rsp_rdata, link_timeout_ms;
   logic [31:0] read_pos, vel_in, status_in, pos_out, eff_steps, eff_range;
   logic nv_params, nv_timeout, fault, net_part, net_ind;
   int mismatches = 0;
   int check_count = 0;

   remote_master master_u (.clk_sys, .req_valid, .req_func, .req_addr,
      .req_wdata, .req_end, .rsp_valid, .rsp_rdata, .rsp_exc,
      .rsp_exc_code);
   encoder_param_registers #(.MS_CYCLES(MS_CYCLES)) dut_u (
      .clk_sys, .rst, .req_valid, .req_func, .req_addr, .req_wdata,
      .req_end, .rsp_valid, .rsp_rdata, .rsp_exc, .rsp_exc_code,
      .scaled_mode, .apply_preset, .commit_cmd, .read_pos, .vel_in,
      .status_in, .pos_out, .eff_steps_per_turn(eff_steps),
      .eff_full_range(eff_range), .link_timeout_ms,
      .nv_save_params(nv_params), .nv_save_timeout(nv_timeout),
      .comm_fault_state(fault), .net_participate(net_part),
      .net_state_indicator(net_ind));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic chk_rsp(input logic [7:0] code, input logic [15:0] data);
      chk({31'h0, master_u.got_valid}, 32'h1, "answer");
      chk({31'h0, master_u.got_exc}, {31'h0, code != 8'h00}, "exc flag");
      chk({24'h0, master_u.got_code}, {24'h0, code}, "exc code");
      chk({16'h0, master_u.got_rdata}, {16'h0, data}, "read data");
   endtask

   task automatic rd32(input logic [15:0] a, input logic [31:0] v);
      master_u.acc(`ENC_FC_READ, a, 16'h0000, 1'b0);
      chk_rsp(8'h00, v[31:16]);
      master_u.acc(`ENC_FC_READ, a + 16'h0001, 16'h0000, 1'b1);
      chk_rsp(8'h00, v[15:0]);
      master_u.idle();
   endtask

   // The value check happens on the low half, so only its answer counts.
   task automatic wr32(input logic [15:0] a, input logic [31:0] v,
                       input logic [7:0] code);
      master_u.acc(`ENC_FC_WR_MANY, a, v[31:16], 1'b0);
      master_u.acc(`ENC_FC_WR_MANY, a + 16'h0001, v[15:0], 1'b1);
      chk_rsp(code, 16'h0000);
      master_u.idle();
   endtask

   task automatic single(input logic [7:0] f, input logic [15:0] a, d,
                         input logic [7:0] code, input logic [15:0] rd);
      master_u.acc(f, a, d, 1'b1);
      chk_rsp(code, rd);
      master_u.idle();
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      {scaled_mode, apply_preset, commit_cmd} = 3'b000;
      read_pos = 32'h1234_5678;
      vel_in = 32'hFFFF_FFF0;
      status_in = 32'h0000_0003;
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      single(`ENC_FC_READ, `ENC_A_TIMEOUT, 16'h0, 8'h00, 16'h0000);
      rd32(`ENC_A_STEPS_HI, 32'h0000_2000);
      rd32(`ENC_A_RANGE_HI, 32'h0800_0000);
      rd32(`ENC_A_PRESET_HI, 32'h0000_0000);
      rd32(`ENC_A_POS_HI, 32'h1234_5678);
      rd32(`ENC_A_VEL_HI, 32'hFFFF_FFF0);
      rd32(`ENC_A_STAT_HI, 32'h0000_0003);
      single(`ENC_FC_WR_ONE, `ENC_A_POS_LO, 16'h0, `ENC_EX_ADDR, 16'h0);
      single(8'h04, `ENC_A_TIMEOUT, 16'h0, `ENC_EX_FUNC, 16'h0);
      single(`ENC_FC_READ, 16'h0070, 16'h0, `ENC_EX_ADDR, 16'h0);
      wr32(`ENC_A_RANGE_HI, 32'h0080_0000, 8'h00);
      wr32(`ENC_A_STEPS_HI, 32'h0000_0800, 8'h00);
      wr32(`ENC_A_STEPS_HI, 32'h0000_2001, `ENC_EX_VALUE);
      wr32(`ENC_A_STEPS_HI, 32'h0000_0000, `ENC_EX_VALUE);
      wr32(`ENC_A_STEPS_HI, 32'h0000_0100, `ENC_EX_VALUE);
      wr32(`ENC_A_RANGE_HI, 32'h0800_0001, `ENC_EX_VALUE);
      wr32(`ENC_A_RANGE_HI, 32'h0000_0000, `ENC_EX_VALUE);
      wr32(`ENC_A_RANGE_HI, 32'h0000_03E8, `ENC_EX_VALUE);
      rd32(`ENC_A_STEPS_HI, 32'h0000_0800);
      rd32(`ENC_A_RANGE_HI, 32'h0080_0000);
      chk(eff_steps, 32'h0000_2000, "native steps");
      scaled_mode = 1'b1;
      @(negedge clk_sys);
      chk(eff_steps, 32'h0000_0800, "scaled steps");
      chk(eff_range, 32'h0080_0000, "scaled range");
      wr32(`ENC_A_PRESET_HI, 32'h0080_0000, `ENC_EX_VALUE);
      wr32(`ENC_A_PRESET_HI, 32'h007F_FFFF, 8'h00);
      wr32(`ENC_A_PRESET_HI, 32'h0000_0032, 8'h00);
      read_pos = 32'h0000_03E8;
      apply_preset = 1'b1;
      @(negedge clk_sys);
      apply_preset = 1'b0;
      chk(pos_out, 32'h0000_0032, "preset applied");
      @(negedge clk_sys);
      read_pos = 32'h0000_03E9;
      @(negedge clk_sys);
      chk(pos_out, 32'h0000_0033, "relative position");
      commit_cmd = 1'b1;
      @(negedge clk_sys);
      commit_cmd = 1'b0;
      chk({31'h0, nv_params}, 32'h1, "commit save");
      master_u.acc(`ENC_FC_WR_ONE, `ENC_A_TIMEOUT, 16'h0003, 1'b1);
      chk({31'h0, nv_timeout}, 32'h1, "timeout saved");
      chk({16'h0, link_timeout_ms}, 32'h3, "timeout reg");
      master_u.idle();
      repeat (40) @(negedge clk_sys);
      chk({31'h0, fault}, 32'h0, "unarmed");
      single(`ENC_FC_READ, `ENC_A_TIMEOUT, 16'h0, 8'h00, 16'h0003);
      single(`ENC_FC_WR_ONE, `ENC_A_TIMEOUT, 16'h0, 8'h00, 16'h0);
      repeat (40) @(negedge clk_sys);
      chk({31'h0, fault}, 32'h0, "disabled");
      single(`ENC_FC_WR_ONE, `ENC_A_TIMEOUT, 16'h3, 8'h00, 16'h0);
      single(`ENC_FC_READ, `ENC_A_TIMEOUT, 16'h0, 8'h00, 16'h0003);
      repeat (15) @(negedge clk_sys);
      single(`ENC_FC_READ, `ENC_A_TIMEOUT, 16'h0, 8'h00, 16'h0003);
      repeat (26) @(negedge clk_sys);
      chk({31'h0, fault}, 32'h0, "restarted");
      for (int n = 0; n < 8 && fault !== 1'b1; n++) @(negedge clk_sys);
      chk({29'h0, fault, net_part, net_ind}, 32'h5, "fault state");
      master_u.acc(`ENC_FC_READ, `ENC_A_TIMEOUT, 16'h0, 1'b1);
      chk({31'h0, master_u.got_valid}, 32'h0, "ignored");
      master_u.idle();
      print_verdict();
   end
endmodule

bind encoder_param_registers encoder_param_registers_checker #(
   .NATIVE_STEPS(NATIVE_STEPS), .NATIVE_TURNS(NATIVE_TURNS),
   .MS_CYCLES(MS_CYCLES)) chk_u (
   .clk_sys, .rst, .req_valid, .req_func, .req_addr, .rsp_valid,
   .rsp_exc, .rsp_exc_code, .scaled_mode, .apply_preset, .commit_cmd,
   .read_pos, .pos_out, .eff_steps_per_turn, .eff_full_range,
   .link_timeout_ms, .nv_save_params, .nv_save_timeout,
   .comm_fault_state, .net_participate, .net_state_indicator);
